// File: logic/cpm_pkg.sv
// Package: constants shared by the configuration parity block
package cpm_pkg;
  // ==========================================
  // Register geometry
  localparam int unsigned WORD_W = 9;
  localparam int unsigned NUM_CFG = 6;
  localparam int unsigned NUM_REGS = 7;
  localparam logic [2:0] COLPAR_IDX = 3'h6;
  localparam int unsigned ROW_PAR_POS = 0;
  localparam int unsigned ROWBITS_POS = 8;
  localparam logic [8:0] CFG_RESET = 9'h000;
  localparam logic [8:0] COLPAR_RESET = 9'h000;
  // ==========================================
  // Register map (byte offsets)
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;
  localparam logic [7:0] ADDR_DETAIL = 8'h28;
  localparam logic [7:0] ADDR_CTRL = 8'h2c;
  // Status and control bits
  localparam int unsigned ST_ROW_ERR = 0;
  localparam int unsigned ST_COL_ERR = 1;
  localparam int unsigned ST_W = 2;
  localparam int unsigned CTRL_CHECK_EN = 0;
  localparam logic CTRL_RESET = 1'b1;
endpackage

// File: logic/cpm_parity_check.sv
// Module: combinational row and column odd-parity checker
`timescale 1ns/1ps
module cpm_parity_check #(
  parameter int unsigned NREG = 7
) (
  // Register image, flattened, register 0 in the low bits
  input wire logic [NREG*9-1:0] regs,
  // Results
  output logic [NREG-1:0] row_bad,
  output logic [8:0] col_bad
);
  // Bit positions below are fixed to the seven-word map
  if (NREG != cpm_pkg::NUM_REGS) begin : g_bad_nreg
    $error("cpm_parity_check supports seven registers only");
  end

  always_comb begin
    logic [8:0] acc;
    acc = '0;
    for (int r = 0; r < NREG; r++) begin
      row_bad[r] = ~(^regs[r*9 +: 9]);
    end
    // Column bit k (1..7) of register 6 covers bit k of registers 0..5
    for (int r = 0; r < NREG; r++) begin
      acc = acc ^ regs[r*9 +: 9];
    end
    col_bad[8:1] = ~acc[8:1];
    col_bad[0] = 1'b0;
    // Bit 8 of register 6 with all row parity bits of registers 0..5
    acc[0] = regs[6*9 + 8];
    for (int r = 0; r < NREG - 1; r++) begin
      acc[0] = acc[0] ^ regs[r*9];
    end
    col_bad[8] = ~acc[0];
  end
endmodule

// File: logic/cpm_top.sv
// Module: parity-protected configuration register bank with error reporting
// Functional notes
// - Config register row bit gives odd parity
// - Column bit plus registers 0-5 odd
// - Column bit k covers data bit k, for k 1-7
// - Bit 8 covers the row parity bits of registers 0-5
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module cpm_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Status
  output logic parity_error,
  output logic irq
);
  // ==========================================
  // Register bank
  logic [8:0] bank_q [cpm_pkg::NUM_REGS];
  logic [8:0] bank_d [cpm_pkg::NUM_REGS];
  logic [cpm_pkg::ST_W-1:0] status_q, status_d, mask_q, mask_d;
  logic ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic [cpm_pkg::NUM_REGS-1:0] row_bad;
  logic [8:0] col_bad;
  logic [cpm_pkg::NUM_REGS*9-1:0] flat;
  logic row_ev, col_ev;

  function automatic logic in_bank(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a[7:2] < 6'(cpm_pkg::NUM_REGS));
  endfunction

  always_comb begin
    for (int r = 0; r < cpm_pkg::NUM_REGS; r++) begin
      flat[r*9 +: 9] = bank_q[r];
    end
  end

  cpm_parity_check #(.NREG(cpm_pkg::NUM_REGS)) u_chk (
    .regs(flat),
    .row_bad(row_bad),
    .col_bad(col_bad)
  );

  // ==========================================
  // Error events; checking is continuous while enabled
  assign row_ev = ctrl_q & (|row_bad);
  assign col_ev = ctrl_q & (|col_bad);

  always_comb begin
    for (int r = 0; r < cpm_pkg::NUM_REGS; r++) begin
      bank_d[r] = bank_q[r];
    end
    status_d = status_q;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    rdata_d = '0;
    if (wr_en) begin
      if (in_bank(addr)) begin
        bank_d[addr[4:2]] = wdata[8:0];
      end else if (addr == cpm_pkg::ADDR_STATUS) begin
        status_d = status_q & ~wdata[cpm_pkg::ST_W-1:0];
      end else if (addr == cpm_pkg::ADDR_MASK) begin
        mask_d = wdata[cpm_pkg::ST_W-1:0];
      end else if (addr == cpm_pkg::ADDR_CTRL) begin
        ctrl_d = wdata[cpm_pkg::CTRL_CHECK_EN];
      end
    end
    // Set wins over a clear in the same cycle
    if (row_ev) begin
      status_d[cpm_pkg::ST_ROW_ERR] = 1'b1;
    end
    if (col_ev) begin
      status_d[cpm_pkg::ST_COL_ERR] = 1'b1;
    end
    if (rd_en) begin
      if (in_bank(addr)) begin
        rdata_d = {23'h000000, bank_q[addr[4:2]]};
      end else if (addr == cpm_pkg::ADDR_STATUS) begin
        rdata_d = {30'h0, status_q};
      end else if (addr == cpm_pkg::ADDR_MASK) begin
        rdata_d = {30'h0, mask_q};
      end else if (addr == cpm_pkg::ADDR_DETAIL) begin
        rdata_d = {16'h0000, col_bad[8:1], 1'b0, row_bad};
      end else if (addr == cpm_pkg::ADDR_CTRL) begin
        rdata_d = {31'h0, ctrl_q};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int r = 0; r < cpm_pkg::NUM_CFG; r++) begin
        bank_q[r] <= cpm_pkg::CFG_RESET;
      end
      bank_q[cpm_pkg::NUM_CFG] <= cpm_pkg::COLPAR_RESET;
      status_q <= '0;
      mask_q <= '0;
      ctrl_q <= cpm_pkg::CTRL_RESET;
      rdata_q <= '0;
    end else if (clk_en) begin
      bank_q <= bank_d;
      status_q <= status_d;
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  // Live flag; the sticky copy sits in status
  assign parity_error = row_ev | col_ev;
  assign irq = |(status_q & mask_q);

  // ==========================================
  // Checks
  a_row_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_q && row_bad != '0) |-> parity_error)
    else $error("row parity failure not flagged");
  a_col_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_q && col_bad[7:1] != '0) |-> parity_error)
    else $error("column parity failure not flagged");
  a_col_map: assert property (@(posedge clk) disable iff (!rst_n)
    col_bad[1] == ~(bank_q[0][1] ^ bank_q[1][1] ^ bank_q[2][1] ^ bank_q[3][1]
      ^ bank_q[4][1] ^ bank_q[5][1] ^ bank_q[6][1]))
    else $error("column bit mapping wrong");
  a_rowbits_column: assert property (@(posedge clk) disable iff (!rst_n)
    col_bad[8] == ~(bank_q[6][8] ^ bank_q[0][0] ^ bank_q[1][0] ^ bank_q[2][0]
      ^ bank_q[3][0] ^ bank_q[4][0] ^ bank_q[5][0]))
    else $error("row parity column wrong");
  a_own_row: assert property (@(posedge clk) disable iff (!rst_n)
    row_bad[6] == ~(^bank_q[6]))
    else $error("column register row parity wrong");
  a_sticky_set: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && row_ev) |=> status_q[cpm_pkg::ST_ROW_ERR])
    else $error("row error not latched");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    (status_q & mask_q) != '0 |-> irq)
    else $error("interrupt not raised");
  a_no_check: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_q |-> !parity_error)
    else $error("flag while checking disabled");
  c_row_err: cover property (@(posedge clk) disable iff (!rst_n) row_ev);
  c_col_err: cover property (@(posedge clk) disable iff (!rst_n) col_ev);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  c_clean: cover property (@(posedge clk) disable iff (!rst_n)
    ctrl_q && !parity_error);
endmodule

// File: test/tb.sv
// Testbench: register-level checks of the configuration parity bank
`timescale 1ns/1ps
module tb;
  // ==========================================
  // Signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic parity_error;
  logic irq;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [8:0] w [7];
  cpm_top dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .parity_error(parity_error), .irq(irq));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Hang guard: the whole sequence needs a few hundred cycles at most
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic load();
    for (int i = 0; i < 7; i++) begin
      wr(8'(4 * i), {23'h0, w[i]});
    end
    repeat (2) @(posedge clk);
    wr(cpm_pkg::ADDR_STATUS, 32'h3);
  endtask
  task automatic summarize();
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h18, 32'h0);
    chk(parity_error, 1'b1);
    rd(cpm_pkg::ADDR_STATUS, 32'h3);
    rd(8'h30, 32'h0);
    // Good bank: row bits odd, column word built from the columns
    for (int i = 0; i < 6; i++) begin
      w[i][8:1] = 8'(8'h3b * (i + 1));
      w[i][0] = ~^w[i][8:1];
    end
    for (int k = 1; k < 9; k++) begin
      w[6][k] = 1'b1;
      for (int i = 0; i < 6; i++) begin
        w[6][k] = w[6][k] ^ w[i][k == 8 ? 0 : k];
      end
    end
    w[6][0] = ~^w[6][8:1];
    wr(cpm_pkg::ADDR_MASK, 32'h3);
    load();
    rd(8'h18, {23'h0, w[6]});
    chk(parity_error, 1'b0);
    rd(cpm_pkg::ADDR_STATUS, 32'h0);
    chk(irq, 1'b0);
    // Data bit 3 of register 2 flipped: row 2 and column 3 fail
    w[2][3] = ~w[2][3];
    load();
    chk(parity_error, 1'b1);
    rd(cpm_pkg::ADDR_STATUS, 32'h3);
    chk(irq, 1'b1);
    rd(cpm_pkg::ADDR_DETAIL, 32'h404);
    // Row bit of register 1 flipped instead: row 1 and the row-bit column fail
    w[2][3] = ~w[2][3];
    w[1][0] = ~w[1][0];
    load();
    rd(cpm_pkg::ADDR_DETAIL, 32'h8002);
    // Masked out, then checking off
    wr(cpm_pkg::ADDR_MASK, 32'h0);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    wr(cpm_pkg::ADDR_CTRL, 32'h0);
    @(posedge clk);
    #1;
    chk(parity_error, 1'b0);
    // Clock enable low: a write must not land
    @(posedge clk);
    clk_en <= 1'b0;
    wr(cpm_pkg::ADDR_MASK, 32'h3);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(cpm_pkg::ADDR_MASK, 32'h0);
    summarize();
  end
endmodule
